// ---- cpbb_bridge.sv ----
`timescale 1ns/10ps
// Functional notes
// [R1] Port uses a reduced parallel protocol without clear, init or done.
// [R2] Port serves readback and partial reconfiguration, never full config.
// [R3] Both reads and writes of configuration data and registers pass.
// [R4] Only single non-burst memory transfers (size 0000, type 000) taken.
// [R5] Bus shim on one side, SRAM-like requests feed the port control.
// [R6] Port clock scheme is fixed at compile time by one switch.
// [R7] Free-running mode wires the bus clock to the port clock.
// [R8] Controlled mode drives port clock from a state machine flop.
// [R9] Controlled mode drives port controls straight from flops.
// [R10] Reads reach the port only when the base address matches.
// [R11] Read byte returns on bits [24:31], bits [0:23] are zero.
// [R12] Writes reach the port only when the base address matches.
// [R13] Writes ignore low address bits and send only bits [24:31].
// [R14] Acknowledge comes only after the port cycle has finished.
// [R15] The system gives every bus slave a unique base address.
// [R16] All control logic runs on the bus-side clock.
// [R17] Enable and direction asserted for one port edge, then released.
// [R18] Generated port clock at most half rate, controls set up before.
module cpbb_bridge
    import cpbb_pkg::*;
#(
    parameter logic        FREE_RUN_CLK = 1'b0,
    parameter logic [0:31] BASE_ADDR    = BASE_ADDR_DFLT
) (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        shim_req,
    input  wire logic        shim_rnw,
    input  wire logic [0:31] shim_side_address,
    input  wire logic [0:31] shim_wdata,
    input  wire logic [0:3]  transfer_size_field,
    input  wire logic [0:2]  transfer_type_field,
    output logic             shim_rd_ack,
    output logic             shim_wr_ack,
    output logic      [0:31] shim_rdata,
    output logic             config_port_clock,
    output logic             cfg_ce_n,
    output logic             cfg_write_n,
    output logic      [7:0]  cfg_din,
    input  wire logic [7:0]  cfg_dout
);

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SETUP,
        ST_STROBE,
        ST_RELEASE,
        ST_ACK
    } cpbb_state_t;

    typedef struct packed {
        cpbb_state_t st;
        logic [3:0]  phase;
        logic        rnw;
        logic        pclk;
        logic        ce_n;
        logic        write_n;
        logic [7:0]  din;
        logic [0:31] rdata;
        logic        rd_ack;
        logic        wr_ack;
    } cpbb_top_st_t;

    localparam cpbb_top_st_t TOP_RST = '{
        st:      ST_IDLE,
        phase:   4'h0,
        rnw:     1'b0,
        pclk:    PCLK_RST,
        ce_n:    CE_N_RST,
        write_n: WRITE_N_RST,
        din:     DIN_RST,
        rdata:   RDATA_RST,
        rd_ack:  1'b0,
        wr_ack:  1'b0
    };

    cpbb_top_st_t     s_q;
    cpbb_top_st_t     s_d;
    logic             buf_valid;
    logic             buf_ready;
    logic [BUF_W-1:0] buf_data;
    logic             phase_done;

    cpbb_req_if rq ();

    // [R5] Shim request side feeds the qualifier.
    assign rq.req        = shim_req;
    assign rq.rnw        = shim_rnw;
    assign rq.addr       = shim_side_address;
    assign rq.wdata      = shim_wdata;
    assign rq.size       = transfer_size_field;
    assign rq.xtype      = transfer_type_field;
    assign rq.ack        = s_q.rd_ack || s_q.wr_ack;

    cpbb_req_decode #(
        .BASE_ADDR (BASE_ADDR)
    ) u_decode (
        .clk     (clk),
        .reset_n (reset_n),
        .rq      (rq.dec_mp)
    );

    // A stall by the port sequencer holds requests here without loss.
    cpbb_buf2 u_buf (
        .clk       (clk),
        .reset_n   (reset_n),
        .in_valid  (rq.push_valid),
        .in_ready  (rq.push_ready),
        .in_data   (rq.push_data),
        .out_valid (buf_valid),
        .out_ready (buf_ready),
        .out_data  (buf_data)
    );

    assign buf_ready  = (s_q.st == ST_IDLE);
    assign phase_done = (s_q.phase == PCLK_HALF_LAST);

    // [R16] One sequencer on the bus-side clock carries every transfer.
    always_comb begin
        s_d        = s_q;
        s_d.rd_ack = 1'b0;
        s_d.wr_ack = 1'b0;
        case (s_q.st)
            ST_IDLE: begin
                if (buf_valid) begin
                    // [R17] Assert enable and direction together.
                    s_d.rnw     = buf_data[BUF_RNW_BIT];
                    s_d.din     = buf_data[7:0];
                    s_d.ce_n    = 1'b0;
                    s_d.write_n = buf_data[BUF_RNW_BIT];
                    s_d.pclk    = 1'b0;
                    s_d.phase   = 4'h0;
                    s_d.st      = ST_SETUP;
                end
            end
            ST_SETUP: begin
                if (FREE_RUN_CLK) begin
                    // [R17] Free clock: enable spans a single edge.
                    s_d.ce_n    = 1'b1;
                    s_d.write_n = WRITE_N_RST;
                    s_d.st      = ST_STROBE;
                end else if (phase_done) begin
                    // [R18] Rising edge only after a full low half.
                    s_d.pclk  = 1'b1;
                    s_d.phase = 4'h0;
                    s_d.st    = ST_STROBE;
                end else begin
                    s_d.phase = s_q.phase + 4'h1;
                end
            end
            ST_STROBE: begin
                if (FREE_RUN_CLK) begin
                    s_d.st = ST_RELEASE;
                end else if (phase_done) begin
                    // [R17] Release after the one controlled edge.
                    s_d.pclk    = 1'b0;
                    s_d.ce_n    = 1'b1;
                    s_d.write_n = WRITE_N_RST;
                    s_d.phase   = 4'h0;
                    s_d.st      = ST_RELEASE;
                end else begin
                    s_d.phase = s_q.phase + 4'h1;
                end
            end
            ST_RELEASE: begin
                // [R14] Port cycle is over, so acknowledge now.
                if (s_q.rnw) begin
                    // [R11] Byte lands on [24:31], upper bits cleared.
                    s_d.rdata = {24'h00_0000, cfg_dout};
                    s_d.rd_ack = 1'b1;
                end else begin
                    s_d.wr_ack = 1'b1;
                end
                s_d.st = ST_ACK;
            end
            ST_ACK: begin
                // The shim drops its request while this cycle ends.
                s_d.st = ST_IDLE;
            end
            default: begin
                s_d = TOP_RST;
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= TOP_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // [R1] [R2] Only enable, direction, clock and data reach the port.
    // [R9] Port controls come straight from flops.
    assign cfg_ce_n    = s_q.ce_n;
    assign cfg_write_n = s_q.write_n;
    assign cfg_din     = s_q.din;
    assign shim_rd_ack = s_q.rd_ack;
    assign shim_wr_ack = s_q.wr_ack;
    // [R3] Read data is held until the next read replaces it.
    assign shim_rdata  = s_q.rdata;

    // [R6] [R7] [R8] Clock source chosen when the design is built.
    // The free clock is the bus clock itself, so its port timing must be
    // closed by constraints rather than by this sequencer.
    assign config_port_clock = FREE_RUN_CLK ? clk : s_q.pclk;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    // The enable is low for one bus cycle in free mode and two otherwise.
    // A tight window keeps the next transfer from closing this sequence.
    sequence s_port_cycle;
        $fell(s_q.ce_n) ##[1:2] $rose(s_q.ce_n);
    endsequence

    sequence s_ack_pulse;
        (s_q.rd_ack || s_q.wr_ack) ##1 !(s_q.rd_ack || s_q.wr_ack);
    endsequence

    sequence s_gen_edge;
        $rose(s_q.pclk) ##1 ($fell(s_q.pclk) && $rose(s_q.ce_n));
    endsequence

    // The free path still passes its strobe state after the release, so
    // its acknowledge comes two cycles after the enable rises, not one as in generated mode.
    a_ack_after_cycle: assert property ( // [R14]
        (!FREE_RUN_CLK) ##0 s_port_cycle |=> s_ack_pulse)
        else $error("Acknowledge missing after port cycle.");

    a_ack_after_free: assert property ( // [R14]
        (FREE_RUN_CLK) ##0 s_port_cycle |=> ##1 s_ack_pulse)
        else $error("Acknowledge missing after free-clock port cycle.");

    a_ack_needs_cycle: assert property ( // [R14]
        $rose(s_q.rd_ack || s_q.wr_ack) |-> $past(s_q.ce_n)
            && $past(s_q.st) == ST_RELEASE)
        else $error("Acknowledge given before port cycle ended.");

    a_rd_byte_only: assert property ( // [R11]
        s_q.rd_ack |-> s_q.rdata[0:23] == 24'h00_0000
            && s_q.rdata[BYTE_FIRST_BIT:BYTE_LAST_BIT] == $past(cfg_dout))
        else $error("Read word not formed from the port byte.");

    a_free_one_edge: assert property ( // [R17]
        FREE_RUN_CLK && $fell(s_q.ce_n) |=> s_q.ce_n && s_q.write_n)
        else $error("Enable held over more than one free edge.");

    a_ctl_setup_edge: assert property ( // [R18]
        !FREE_RUN_CLK && $rose(s_q.pclk) |-> !s_q.ce_n
            && $stable(s_q.ce_n) && $stable(s_q.write_n) && $stable(s_q.din))
        else $error("Controls changed at a generated clock edge.");

    // A half period may end only once its cycle counter has run out.
    a_pclk_half_rate: assert property ( // [R18]
        !FREE_RUN_CLK && $changed(s_q.pclk)
            |-> $past(s_q.phase) == PCLK_HALF_LAST)
        else $error("Generated clock faster than half rate.");

    a_dir_matches_req: assert property ( // [R17]
        $fell(s_q.ce_n) |-> s_q.write_n == s_q.rnw
            && s_q.din == $past(buf_data[7:0]))
        else $error("Direction or byte not taken from request.");

    a_idle_released: assert property ( // [R1]
        s_q.st == ST_IDLE |-> s_q.ce_n && s_q.write_n)
        else $error("Port enabled while sequencer idle.");

    a_gen_one_edge: assert property ( // [R17]
        !FREE_RUN_CLK && $fell(s_q.ce_n) |=> s_gen_edge)
        else $error("Generated clock gave no single edge under enable.");

    a_ce_after_req: assert property ( // [R10]
        $fell(s_q.ce_n) |-> $past(buf_valid))
        else $error("Port enabled without an accepted request.");

    a_ce_write_pair: assert property ( // [R17]
        s_q.ce_n |-> s_q.write_n)
        else $error("Direction left asserted after enable release.");

    // The byte and direction are set with the enable and must then sit
    // still for the whole strobe.
    a_ctl_steady: assert property ( // [R18]
        !s_q.ce_n && !$fell(s_q.ce_n)
            |-> $stable(s_q.din) && $stable(s_q.write_n))
        else $error("Byte or direction moved during a port strobe.");

    a_ack_one_kind: assert property ( // [R14]
        !(s_q.rd_ack && s_q.wr_ack))
        else $error("Read and write acknowledge raised together.");

    a_ack_kind_dir: assert property ( // [R3]
        s_q.rd_ack || s_q.wr_ack |-> s_q.rd_ack == s_q.rnw)
        else $error("Acknowledge kind differs from transfer direction.");

    a_rdata_holds: assert property ( // [R3]
        $changed(s_q.rdata) |-> s_q.rd_ack)
        else $error("Read word changed without a read acknowledge.");

    a_gen_clk_idle: assert property ( // [R18]
        !FREE_RUN_CLK && s_q.st == ST_IDLE |-> !s_q.pclk)
        else $error("Generated clock left high between transfers.");

endmodule : cpbb_bridge

// ---- cpbb_bridge_tb_top.sv ----
`timescale 1ns/10ps
module cpbb_bridge_tb_top;
    import cpbb_pkg::*;

    logic        clk;
    logic        reset_n;
    logic        req       [2];
    logic        rnw       [2];
    logic [0:31] addr      [2];
    logic [0:31] wdata     [2];
    logic [0:3]  size      [2];
    logic [0:2]  xtype     [2];
    logic        rd_ack    [2];
    logic        wr_ack    [2];
    logic [0:31] rdata     [2];
    logic        pclk      [2];
    logic        ce_n      [2];
    logic        write_n   [2];
    logic [7:0]  din       [2];
    logic [7:0]  dout      [2];
    logic [7:0]  rd_byte   [2];
    logic [7:0]  wr_byte   [2];
    int          edge_cnt  [2];
    logic [0:33] exp_q     [$];
    logic [0:33] mon_e;
    logic [31:0] seed;
    logic [31:0] v;
    int          failures;
    int          cmp_count;
    int          cyc;

    // Raising edge to acknowledge sample, the same in both clock modes.
    localparam int ACK_EDGES = 6;

    // Index 0 uses the generated port clock, index 1 the bus clock.
    for (genvar g = 0; g < 2; g++) begin : g_pair
        cpbb_bridge #(
            .FREE_RUN_CLK(g == 1),
            .BASE_ADDR   (BASE_ADDR_DFLT)
        ) u_cpbb_bridge (
            .clk                (clk),
            .reset_n            (reset_n),
            .shim_req           (req[g]),
            .shim_rnw           (rnw[g]),
            .shim_side_address  (addr[g]),
            .shim_wdata         (wdata[g]),
            .transfer_size_field(size[g]),
            .transfer_type_field(xtype[g]),
            .shim_rd_ack        (rd_ack[g]),
            .shim_wr_ack        (wr_ack[g]),
            .shim_rdata         (rdata[g]),
            .config_port_clock  (pclk[g]),
            .cfg_ce_n           (ce_n[g]),
            .cfg_write_n        (write_n[g]),
            .cfg_din            (din[g]),
            .cfg_dout           (dout[g])
        );
        cpbb_port_model u_cpbb_port_model (
            .pclk    (pclk[g]),
            .ce_n    (ce_n[g]),
            .write_n (write_n[g]),
            .din     (din[g]),
            .rd_byte (rd_byte[g]),
            .dout    (dout[g]),
            .wr_byte (wr_byte[g]),
            .edge_cnt(edge_cnt[g])
        );
    end

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic do_reset();
        reset_n <= 1'b0;
        repeat (5) @(posedge clk);
        for (int m = 0; m < 2; m++) begin
            check("ce_n in reset", ce_n[m], CE_N_RST);
            check("write_n in reset", write_n[m], WRITE_N_RST);
            check("din in reset", din[m], DIN_RST);
            check("rdata in reset", rdata[m], RDATA_RST);
            check("acks in reset", rd_ack[m] | wr_ack[m], 0);
        end
        check("port clock in reset", pclk[0], PCLK_RST);
        reset_n <= 1'b1;
    endtask : do_reset

    // The byte in d[24:31] is written on writes and returned on reads.
    task automatic xfer(int m, logic r, logic [0:31] a, logic [0:31] d,
                        logic [0:3] sz, logic [0:2] ty, logic ok);
        int n;
        int c0;
        n  = 0;
        c0 = edge_cnt[m];
        @(posedge clk);
        req[m]     <= 1'b1;
        rnw[m]     <= r;
        addr[m]    <= a;
        wdata[m]   <= d;
        size[m]    <= sz;
        xtype[m]   <= ty;
        rd_byte[m] <= d[24:31];
        if (ok) begin
            exp_q.push_back({m[0], r, 24'h00_0000, d[24:31]});
        end
        do begin
            @(posedge clk);
            n++;
        end while ((rd_ack[m] | wr_ack[m]) !== 1'b1 && n < 12);
        req[m] <= 1'b0;
        check("ack latency", n, ok ? ACK_EDGES : 12);
        check("port cycles", edge_cnt[m] - c0, ok);
    endtask : xfer

    always @(posedge clk) begin
        for (int m = 0; m < 2; m++) begin
            if ((rd_ack[m] | wr_ack[m]) === 1'b1) begin
                if (exp_q.size() == 0) begin
                    check("unexpected ack", 1, 0);
                end else begin
                    mon_e = exp_q.pop_front();
                    check("ack mode", m, mon_e[0]);
                    check("ack kind", rd_ack[m], mon_e[1]);
                    if (mon_e[1]) begin
                        check("read word", rdata[m], mon_e[2:33]);
                    end else begin
                        check("port byte", wr_byte[m], mon_e[2:33]);
                    end
                end
            end
        end
    end

    // The port clock passes through a continuous assignment, so it is
    // looked at just after each clock edge, never in the edge's own step.
    always @(clk) begin
        #1;
        if (reset_n === 1'b1) begin
            check("free port clock", pclk[1], clk);
        end
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            failures++;
            tally_and_finish();
        end
    end

    initial begin
        reset_n   = 1'b0;
        seed      = 32'h0000_09DF;
        failures  = 0;
        cmp_count = 0;
        cyc       = 0;
        for (int m = 0; m < 2; m++) begin
            req[m]     = 1'b0;
            rnw[m]     = 1'b0;
            addr[m]    = 32'h0000_0000;
            wdata[m]   = 32'h0000_0000;
            size[m]    = 4'h0;
            xtype[m]   = 3'h0;
            rd_byte[m] = 8'h00;
        end
        do_reset();
        for (int m = 0; m < 2; m++) begin
            for (int i = 0; i < 8; i++) begin
                v = rnd();
                xfer(m, i[0], {BASE_ADDR_DFLT[0:23], v[7:0]}, rnd(),
                     4'h0, 3'h0, 1'b1);
            end
            $display("mode %0d accepted transfers done", m);
            for (int k = 0; k < 4; k++) begin
                v = {BASE_ADDR_DFLT[0:23], 8'h00};
                xfer(m, k[0], k < 2 ? v ^ 32'h0000_0100 : v, rnd(),
                     k == 2 ? 4'h1 : 4'h0, k == 3 ? 3'h1 : 3'h0, 1'b0);
            end
            $display("mode %0d refused transfers done", m);
        end
        do_reset();
        $display("mid-run reset done");
        xfer(0, 1'b1, BASE_ADDR_DFLT, rnd(), 4'h0, 3'h0, 1'b1);
        xfer(1, 1'b0, BASE_ADDR_DFLT, rnd(), 4'h0, 3'h0, 1'b1);
        $display("transfers after reset done");
        repeat (3) @(posedge clk);
        tally_and_finish();
    end
endmodule : cpbb_bridge_tb_top

// ---- cpbb_buf2.sv ----
`timescale 1ns/10ps
module cpbb_buf2
    import cpbb_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [BUF_W-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [BUF_W-1:0] out_data
);

    typedef struct packed {
        logic [1:0][BUF_W-1:0] mem;
        logic                  wp;
        logic                  rp;
        logic [1:0]            cnt;
    } cpbb_buf_st_t;

    cpbb_buf_st_t s_q;
    cpbb_buf_st_t s_d;
    logic         push;
    logic         pop;

    assign in_ready  = (s_q.cnt != 2'h2);
    assign out_valid = (s_q.cnt != 2'h0);
    assign out_data  = s_q.mem[s_q.rp];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.mem[s_q.wp] = in_data;
            s_d.wp          = !s_q.wp;
        end
        if (pop) begin
            s_d.rp = !s_q.rp;
        end
        if (push && !pop) begin
            s_d.cnt = s_q.cnt + 2'h1;
        end else if (pop && !push) begin
            s_d.cnt = s_q.cnt - 2'h1;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_buf_no_overrun: assert property ( // [R14]
        s_q.cnt == 2'h2 |-> !in_ready && s_q.wp == s_q.rp)
        else $error("Full buffer still offers room.");

endmodule : cpbb_buf2

// ---- cpbb_pkg.sv ----
package cpbb_pkg;

    // Shim transfer qualifiers: only single, non-burst memory transfers.
    localparam logic [0:3]  XFER_SIZE_SINGLE = 4'h0;
    localparam logic [0:2]  XFER_TYPE_MEMORY = 3'h0;

    // Address decode: bits [0:23] select the slave, low bits are ignored.
    localparam int          DEC_LAST_BIT     = 23;
    localparam logic [0:31] BASE_ADDR_DFLT   = 32'h4000_0000;

    // Position of the configuration byte inside a 32-bit bus word.
    localparam int          BYTE_FIRST_BIT   = 24;
    localparam int          BYTE_LAST_BIT    = 31;

    // Buffer entry layout: {read-not-write, write byte}.
    localparam int          BUF_W            = 9;
    localparam int          BUF_RNW_BIT      = 8;

    // Reset values of the port controls and returned data.
    localparam logic        CE_N_RST         = 1'b1;
    localparam logic        WRITE_N_RST      = 1'b1;
    localparam logic        PCLK_RST         = 1'b0;
    localparam logic [7:0]  DIN_RST          = 8'h00;
    localparam logic [0:31] RDATA_RST        = 32'h0000_0000;

    // Generated port clock: each half period lasts at least this long.
    localparam int          CLK_PERIOD_NS    = 25;
    localparam int          PCLK_HALF_MIN_NS = 25;
    localparam int          PCLK_HALF_CYC    =
        (PCLK_HALF_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0]  PCLK_HALF_LAST   = 4'(PCLK_HALF_CYC - 1);

endpackage : cpbb_pkg

// ---- cpbb_port_model.sv ----
`timescale 1ns/10ps
module cpbb_port_model (
    input  wire logic       pclk,
    input  wire logic       ce_n,
    input  wire logic       write_n,
    input  wire logic [7:0] din,
    input  wire logic [7:0] rd_byte,
    output logic      [7:0] dout,
    output logic      [7:0] wr_byte,
    output int              edge_cnt
);
    int hold_q;

    initial begin
        dout     = 8'h00;
        wr_byte  = 8'h00;
        edge_cnt = 0;
        hold_q   = 0;
    end

    always @(posedge pclk) begin
        if (ce_n === 1'b0) begin
            edge_cnt <= edge_cnt + 1;
            if (write_n === 1'b0) begin
                wr_byte <= din;
            end else begin
                dout   <= rd_byte;
                hold_q <= 2;
            end
        end else if (hold_q > 0) begin
            hold_q <= hold_q - 1;
        end else begin
            // Once the hold runs out the old byte must not linger.
            dout <= ~dout;
        end
    end
endmodule : cpbb_port_model

// ---- cpbb_req_decode.sv ----
`timescale 1ns/10ps
module cpbb_req_decode
    import cpbb_pkg::*;
#(
    parameter logic [0:31] BASE_ADDR = BASE_ADDR_DFLT
) (
    input  wire logic clk,
    input  wire logic reset_n,
    cpbb_req_if.dec_mp rq
);

    typedef struct packed {
        logic pending;
    } cpbb_dec_st_t;

    cpbb_dec_st_t s_q;
    cpbb_dec_st_t s_d;
    logic         legal;
    logic         match;

    // [R4] Transfer qualification.
    assign legal = (rq.size == XFER_SIZE_SINGLE)
                && (rq.xtype == XFER_TYPE_MEMORY);
    // [R10] [R12] Base address decode.
    assign match = (rq.addr[0:DEC_LAST_BIT] == BASE_ADDR[0:DEC_LAST_BIT]);

    // [R13] Only the low byte travels on.
    assign rq.push_data  = {rq.rnw, rq.wdata[BYTE_FIRST_BIT:BYTE_LAST_BIT]};
    assign rq.push_valid = rq.req && legal && match && !s_q.pending;

    // The shim holds its request until acknowledged, so one capture only.
    always_comb begin
        s_d = s_q;
        if (rq.push_valid && rq.push_ready) begin
            s_d.pending = 1'b1;
        end else if (rq.ack) begin
            s_d.pending = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_bad_xfer_ignored: assert property ( // [R4]
        rq.req && !legal |-> !rq.push_valid)
        else $error("Burst or non-memory transfer was accepted.");

    a_single_capture: assert property ( // [R10]
        rq.push_valid && rq.push_ready |=> !rq.push_valid)
        else $error("One request was captured twice.");

endmodule : cpbb_req_decode

// ---- cpbb_req_if.sv ----
`timescale 1ns/10ps
interface cpbb_req_if;
    import cpbb_pkg::*;

    logic              req;
    logic              rnw;
    logic [0:31]       addr;
    logic [0:31]       wdata;
    logic [0:3]        size;
    logic [0:2]        xtype;
    logic              ack;
    logic              push_valid;
    logic              push_ready;
    logic [BUF_W-1:0]  push_data;

    modport dec_mp (
        input  req,
        input  rnw,
        input  addr,
        input  wdata,
        input  size,
        input  xtype,
        input  ack,
        input  push_ready,
        output push_valid,
        output push_data
    );

    modport top_mp (
        output req,
        output rnw,
        output addr,
        output wdata,
        output size,
        output xtype,
        output ack,
        output push_ready,
        input  push_valid,
        input  push_data
    );

endinterface : cpbb_req_if
